/* led_link_params.svh */
// Purpose: constants for the LED driver serial command link
// Assumes: included by the device, host and test files of the link
// Notes: edge counts select commands in pairs
`ifndef LED_LINK_PARAMS_SVH
`define LED_LINK_PARAMS_SVH
`define CMD_DATA_LATCH 4'h0
`define CMD_GLOBAL_LATCH 4'h1
`define CMD_READ_CFG 4'h2
`define CMD_ERR_DETECT 4'h3
`define CMD_READ_ERR 4'h4
`define CMD_WRITE_CFG 4'h5
`define CMD_RESET_PWM 4'h6
`define CFG_RESET 16'h02AC
`define CFG_BIT_LOAD 15
`define CFG_BIT_THERM 14
`define CFG_BIT_WIDTH 13
`define CFG_BIT_RSTEN 11
`define HALF_DIV 4'h4
`define ADDR_CTRL 8'h00
`define ADDR_WDATA 8'h04
`define ADDR_STATUS 8'h08
`define ADDR_RDATA 8'h0C
`endif

/* led_link_pkg.sv */
// Purpose: types for the LED driver serial command link
// Assumes: nothing
// Notes: none
package led_link_pkg;
	typedef enum logic [1:0] {H_IDLE, H_SHIFT, H_STROBE, H_GAP} host_state_t;
endpackage : led_link_pkg

/* led_link_if.sv */
// Purpose: pins between display controller and LED driver
// Assumes: all pins are single-ended, driven one way
// Notes: none
interface led_link_if;
	logic serial_in;
	logic serial_out;
	logic shift_clock;
	logic strobe_line;
	logic gray_clock_in;
	modport host (output serial_in, output shift_clock, output strobe_line,
		output gray_clock_in, input serial_out);
	modport device (input serial_in, input shift_clock, input strobe_line,
		input gray_clock_in, output serial_out);
endinterface : led_link_if

/* pin_sync.sv */
// Purpose: two-flop synchroniser for a vector of pins
// Assumes: inputs are asynchronous to pclk
// Notes: none
module pin_sync #(
	parameter int WIDTH = 4
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Pins
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] pin_out
);
	logic [WIDTH-1:0] meta_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_r <= '0;
			pin_out <= '0;
		end else begin
			meta_r <= pin_in;
			pin_out <= meta_r;
		end
	end
endmodule : pin_sync

/* led_driver_device.sv */
// Function
// - Command runs at strobe fall, by edge count
// - Count 0-1: shift word into next buffer
// - Count 2-3: buffers go to comparators
// - Count 4-5: config word into shift register
// - Count 6-7: start open-circuit detection
// - Count 8-9: error bits into shift register
// - Count 10-11: shift register into config
// - Count 12-13: reset PWM if permitted
// - Bit F zero: fifteen latches, global stores sixteenth
// - Bit F one: sixteen latches plus global
// - Buffers filled MSB first, channel 15 first
// - Sixteen-bit gray value sets PWM duty
// - Detection drives test current, compares threshold
// - Error bit zero means open, one normal
// - Status shifts out while new data enters
// - Host sends read right after detection
// - Detection spans detect fall to read fall
// - Config bit 15 picks loading scheme
// - Config bit 13 picks 16 or 12 bit counter
// - Config bit 11 permits counter reset
//
// Purpose: device end of the LED driver serial command link
// Assumes: analog sink compare arrives as channel_ok, asynchronous
// Notes: pins are sampled by pclk through pin_sync
//
// Local design decisions: the APB register port and the register offsets.
`include "led_link_params.svh"
module led_driver_device #(
	parameter int CHANNELS = 16,
	parameter int WORD = 16
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Link
	led_link_if.device link,
	// Analog side
	input wire logic [CHANNELS-1:0] channel_ok,
	input wire logic over_temp,
	output logic [CHANNELS-1:0] current_sink_channels,
	output logic test_current_on,
	output logic [WORD-1:0] config_word
);
	import led_link_pkg::*;

	// ----------------------------------------
	// Pin sampling
	// ----------------------------------------
	logic [3:0] pins_s;
	logic [CHANNELS-1:0] ok_s;
	logic temp_s;
	pin_sync #(.WIDTH(4)) u_pins (
		.pclk(pclk),
		.presetn(presetn),
		.pin_in({link.serial_in, link.shift_clock, link.strobe_line, link.gray_clock_in}),
		.pin_out(pins_s)
	);
	pin_sync #(.WIDTH(CHANNELS)) u_ok (
		.pclk(pclk),
		.presetn(presetn),
		.pin_in(channel_ok),
		.pin_out(ok_s)
	);
	pin_sync #(.WIDTH(1)) u_temp (
		.pclk(pclk),
		.presetn(presetn),
		.pin_in(over_temp),
		.pin_out(temp_s)
	);
	logic din_s, shc_s, stb_s, gry_s;
	assign {din_s, shc_s, stb_s, gry_s} = pins_s;

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic shc_d_r, stb_d_r, gry_d_r;
	logic [WORD-1:0] shift_r, shift_nxt;
	logic [WORD-1:0] cfg_r, cfg_nxt;
	logic [3:0] edges_r, edges_nxt;
	logic [3:0] slot_r, slot_nxt;
	logic [WORD-1:0] buf_r [CHANNELS];
	logic [WORD-1:0] buf_nxt [CHANNELS];
	logic [WORD-1:0] cmp_r [CHANNELS];
	logic [WORD-1:0] cmp_nxt [CHANNELS];
	logic detect_r, detect_nxt;
	logic [WORD-1:0] pwm_r, pwm_nxt;
	logic [CHANNELS-1:0] sink_r, sink_nxt;
	logic dout_r, dout_nxt;

	logic shc_rise, stb_rise, stb_fall, gry_rise;
	logic [3:0] cmd;
	assign shc_rise = shc_s & ~shc_d_r;
	assign stb_rise = stb_s & ~stb_d_r;
	assign stb_fall = ~stb_s & stb_d_r;
	assign gry_rise = gry_s & ~gry_d_r;
	assign cmd = {1'b0, edges_r[3:1]};

	always_comb begin
		shift_nxt = shift_r;
		cfg_nxt = cfg_r;
		edges_nxt = edges_r;
		slot_nxt = slot_r;
		buf_nxt = buf_r;
		cmp_nxt = cmp_r;
		detect_nxt = detect_r;
		pwm_nxt = pwm_r;
		dout_nxt = shift_r[WORD-1];
		cfg_nxt[`CFG_BIT_THERM] = temp_s;
		if (stb_rise) begin
			edges_nxt = 4'h0;
		end else if (shc_rise && stb_s && edges_r != 4'hF) begin
			edges_nxt = edges_r + 4'h1;
		end
		if (shc_rise) begin
			shift_nxt = {shift_r[WORD-2:0], din_s};
		end
		if (gry_rise) begin
			pwm_nxt = pwm_r + 16'h0001;
			if (cfg_r[`CFG_BIT_WIDTH] && pwm_r[11:0] == 12'hFFF) begin
				pwm_nxt = 16'h0000;
			end
		end
		if (stb_fall) begin
			case (cmd)
				`CMD_DATA_LATCH: begin
					buf_nxt[slot_r] = shift_r;
					slot_nxt = slot_r + 4'h1;
				end
				`CMD_GLOBAL_LATCH: begin
					if (!cfg_r[`CFG_BIT_LOAD]) begin
						buf_nxt[slot_r] = shift_r;
					end
					for (int i = 0; i < CHANNELS; i++) begin
						cmp_nxt[CHANNELS-1-i] = cfg_r[`CFG_BIT_LOAD] ? buf_r[i] : buf_nxt[i];
					end
					slot_nxt = 4'h0;
				end
				`CMD_READ_CFG: shift_nxt = cfg_r;
				`CMD_ERR_DETECT: detect_nxt = 1'b1;
				`CMD_READ_ERR: begin
					shift_nxt = ok_s;
					detect_nxt = 1'b0;
				end
				`CMD_WRITE_CFG: begin
					cfg_nxt = shift_r;
					cfg_nxt[`CFG_BIT_THERM] = temp_s;
				end
				`CMD_RESET_PWM: begin
					if (cfg_r[`CFG_BIT_RSTEN]) begin
						pwm_nxt = 16'h0000;
					end
				end
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// PWM compare
	// ----------------------------------------
	always_comb begin
		for (int c = 0; c < CHANNELS; c++) begin
			if (detect_r) begin
				sink_nxt[c] = 1'b1;
			end else if (cfg_r[`CFG_BIT_WIDTH]) begin
				sink_nxt[c] = pwm_r[11:0] < cmp_r[c][15:4];
			end else begin
				sink_nxt[c] = pwm_r < cmp_r[c];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shc_d_r <= 1'b0;
			stb_d_r <= 1'b0;
			gry_d_r <= 1'b0;
			shift_r <= '0;
			cfg_r <= `CFG_RESET;
			edges_r <= 4'h0;
			slot_r <= 4'h0;
			for (int i = 0; i < CHANNELS; i++) begin
				buf_r[i] <= '0;
				cmp_r[i] <= '0;
			end
			detect_r <= 1'b0;
			pwm_r <= '0;
			sink_r <= '0;
			dout_r <= 1'b0;
		end else begin
			shc_d_r <= shc_s;
			stb_d_r <= stb_s;
			gry_d_r <= gry_s;
			shift_r <= shift_nxt;
			cfg_r <= cfg_nxt;
			edges_r <= edges_nxt;
			slot_r <= slot_nxt;
			buf_r <= buf_nxt;
			cmp_r <= cmp_nxt;
			detect_r <= detect_nxt;
			pwm_r <= pwm_nxt;
			sink_r <= sink_nxt;
			dout_r <= dout_nxt;
		end
	end

	assign link.serial_out = dout_r;
	assign current_sink_channels = sink_r;
	assign test_current_on = detect_r;
	assign config_word = cfg_r;
endmodule : led_driver_device

/* led_driver_host.sv */
// Purpose: host end; APB registers order commands on the link
// Assumes: device samples pins with its own clock
// Notes: control write starts a 16-bit frame; strobe spans its last edges
`include "led_link_params.svh"
module led_driver_host (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Link
	led_link_if.host link
);
	import led_link_pkg::*;

	// ----------------------------------------
	// Registers and sequencer
	// ----------------------------------------
	logic [1:0] so_sync_r;
	host_state_t st_r, st_nxt;
	logic [15:0] wdata_r, wdata_nxt, tx_r, tx_nxt, rx_r, rx_nxt, rdata_r, rdata_nxt;
	logic [3:0] edges_r, edges_nxt, div_r, div_nxt;
	logic sclk_r, sclk_nxt, stb_r, stb_nxt, din_r, din_nxt, busy_r, busy_nxt;
	logic [4:0] bits_r, bits_nxt;
	logic [31:0] prdata_nxt;
	logic pready_r, pready_nxt, pslverr_r, pslverr_nxt, gray_r, gray_nxt;
	logic wr;
	assign wr = psel & penable & pwrite & ~pready_r;

	always_comb begin
		st_nxt = st_r;
		wdata_nxt = wdata_r;
		tx_nxt = tx_r;
		rx_nxt = rx_r;
		rdata_nxt = rdata_r;
		edges_nxt = edges_r;
		div_nxt = div_r + 4'h1;
		sclk_nxt = sclk_r;
		stb_nxt = stb_r;
		din_nxt = din_r;
		gray_nxt = gray_r;
		busy_nxt = busy_r;
		bits_nxt = bits_r;
		pready_nxt = psel & penable & ~pready_r;
		pslverr_nxt = 1'b0;
		prdata_nxt = 32'h00000000;
		if (psel && penable && !pready_r) begin
			case (paddr)
				`ADDR_CTRL: if (wr && !busy_r) begin
					edges_nxt = pwdata[3:0];
					tx_nxt = wdata_r;
					din_nxt = wdata_r[15];
					bits_nxt = 5'h10;
					busy_nxt = 1'b1;
					st_nxt = H_SHIFT;
					div_nxt = 4'h0;
				end
				`ADDR_WDATA: begin
					if (wr) wdata_nxt = pwdata[15:0];
					prdata_nxt = {16'h0000, wdata_r};
				end
				`ADDR_STATUS: prdata_nxt = {31'h00000000, busy_r};
				`ADDR_RDATA: prdata_nxt = {16'h0000, rdata_r};
				default: pslverr_nxt = 1'b1;
			endcase
		end
		if (div_r == `HALF_DIV - 4'h1) begin
			div_nxt = 4'h0;
			// Toggling on the tick keeps every gray phase at least four cycles
			gray_nxt = ~gray_r;
			case (st_r)
				H_IDLE: ;
				H_SHIFT: begin
					if (!sclk_r) begin
						if (bits_r != 5'h00) begin
							sclk_nxt = 1'b1;
						end else begin
							st_nxt = H_STROBE;
						end
					end else begin
						// Data moves with the clock low, so it stands across the rise
						sclk_nxt = 1'b0;
						tx_nxt = {tx_r[14:0], 1'b0};
						din_nxt = tx_r[14];
						rx_nxt = {rx_r[14:0], so_sync_r[1]};
						bits_nxt = bits_r - 5'h01;
						// Strobe covers the last edges of the frame, giving the count
						if (bits_r - 5'h01 == {1'b0, edges_r}) begin
							stb_nxt = 1'b1;
						end
					end
				end
				H_STROBE: begin
					stb_nxt = 1'b0;
					st_nxt = H_GAP;
				end
				H_GAP: begin
					rdata_nxt = rx_r;
					busy_nxt = 1'b0;
					st_nxt = H_IDLE;
				end
				default: st_nxt = H_IDLE;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			so_sync_r <= 2'h0;
			st_r <= H_IDLE;
			wdata_r <= 16'h0000;
			tx_r <= 16'h0000;
			rx_r <= 16'h0000;
			rdata_r <= 16'h0000;
			edges_r <= 4'h0;
			div_r <= 4'h0;
			sclk_r <= 1'b0;
			stb_r <= 1'b0;
			din_r <= 1'b0;
			busy_r <= 1'b0;
			bits_r <= 5'h00;
			prdata <= 32'h00000000;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			gray_r <= 1'b0;
		end else begin
			so_sync_r <= {so_sync_r[0], link.serial_out};
			st_r <= st_nxt;
			wdata_r <= wdata_nxt;
			tx_r <= tx_nxt;
			rx_r <= rx_nxt;
			rdata_r <= rdata_nxt;
			edges_r <= edges_nxt;
			div_r <= div_nxt;
			sclk_r <= sclk_nxt;
			stb_r <= stb_nxt;
			din_r <= din_nxt;
			busy_r <= busy_nxt;
			bits_r <= bits_nxt;
			prdata <= prdata_nxt;
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
			gray_r <= gray_nxt;
		end
	end

	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign link.shift_clock = sclk_r;
	assign link.strobe_line = stb_r;
	assign link.serial_in = din_r;
	assign link.gray_clock_in = gray_r;
endmodule : led_driver_host

/* led_link_chk.sv */
// Purpose: wire checks on the LED link pins
// Assumes: all pins sampled in the pclk domain
// Notes: none
module led_link_chk (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Link pins
	input wire logic serial_in,
	input wire logic serial_out,
	input wire logic shift_clock,
	input wire logic strobe_line,
	input wire logic gray_clock_in
);
	logic sc_r, st_r;
	logic [3:0] since_r;
	logic [4:0] bits_r;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ---
	// Edge history
	// ---
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sc_r <= 1'b0;
			st_r <= 1'b0;
			since_r <= 4'hF;
			bits_r <= 5'h00;
		end else begin
			sc_r <= shift_clock;
			st_r <= strobe_line;
			if ((shift_clock && !sc_r) || (st_r && !strobe_line)) begin
				since_r <= 4'h0;
			end else if (since_r != 4'hF) begin
				since_r <= since_r + 4'h1;
			end
			if (st_r && !strobe_line) begin
				bits_r <= 5'h00;
			end else if (shift_clock && !sc_r) begin
				bits_r <= bits_r + 5'h01;
			end
		end
	end
	sequence s_high_half;
		shift_clock [*4] ##1 !shift_clock;
	endsequence
	sequence s_low_half;
		!shift_clock [*4];
	endsequence
	a_rise_quiet: assert property ($rose(strobe_line) |-> !shift_clock)
		else $error("strobe rose with clock high");
	a_fall_quiet: assert property ($fell(strobe_line) |-> !shift_clock)
		else $error("strobe fell with clock high");
	a_strobe_bound: assert property ($rose(strobe_line) |-> ##[1:200] $fell(strobe_line))
		else $error("strobe held too long");
	a_high_half: assert property ($rose(shift_clock) |-> s_high_half)
		else $error("clock high phase wrong");
	a_low_half: assert property ($fell(shift_clock) |-> s_low_half)
		else $error("clock low phase short");
	a_data_hold: assert property (shift_clock && $past(shift_clock) |-> $stable(serial_in))
		else $error("data moved with clock high");
	a_frame_bits: assert property ($fell(strobe_line) |-> bits_r == 5'h10)
		else $error("frame not sixteen bits");
	a_gray_steady: assert property ($changed(gray_clock_in) |=> $stable(gray_clock_in) [*3])
		else $error("gray clock phase short");
	a_out_cause: assert property ($changed(serial_out) |-> since_r <= 4'h8)
		else $error("serial out moved without cause");
endmodule : led_link_chk

/* test_led_driver_serial_command.sv */
// Purpose: run commands across both link ends
// Assumes: host reports busy until a frame ends
// Notes: none
`include "led_link_params.svh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_errors++; \
	$display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module test_led_driver_serial_command;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic over_temp, test_current_on;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] channel_ok, current_sink_channels, config_word, seen;
	int n_errors = 0;
	int samples_checked = 0;
	led_link_if link ();
	led_driver_host i_led_driver_host (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link.host));
	led_driver_device i_led_driver_device (.pclk(pclk), .presetn(presetn),
		.link(link.device), .channel_ok(channel_ok), .over_temp(over_temp),
		.current_sink_channels(current_sink_channels),
		.test_current_on(test_current_on), .config_word(config_word));
	led_link_chk i_led_link_chk (.pclk(pclk), .presetn(presetn),
		.serial_in(link.serial_in), .serial_out(link.serial_out),
		.shift_clock(link.shift_clock), .strobe_line(link.strobe_line),
		.gray_clock_in(link.gray_clock_in));
	// ---
	// Bus tasks
	// ---
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic send(input logic [3:0] edges, input logic [15:0] word);
		apb(1'b1, `ADDR_WDATA, {16'h0000, word});
		apb(1'b1, `ADDR_CTRL, {28'h0000000, edges});
		do begin
			apb(1'b0, `ADDR_STATUS, 32'h00000000);
		end while (rd[0] !== 1'b0);
	endtask : send
	task automatic read_back(input logic [3:0] edges);
		send(edges, 16'h0000);
		send(4'h0, 16'h0000);
		apb(1'b0, `ADDR_RDATA, 32'h00000000);
	endtask : read_back
	task automatic conclude();
		$display("errors=%0d checks=%0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : conclude
	// ---
	// Tests
	// ---
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	initial begin
		#(50 * 60000);
		n_errors++;
		conclude();
	end
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		over_temp = 1'b0;
		channel_ok = 16'hFFFF;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		`CHK(config_word, 16'h02AC)
		read_back(4'h4);
		`CHK(rd[15:0], 16'h02AC)
		send(4'hA, 16'hA801);
		`CHK(config_word, 16'hA801)
		over_temp <= 1'b1;
		read_back(4'h4);
		`CHK(rd[15:0], 16'hE801)
		over_temp <= 1'b0;
		channel_ok <= 16'h5A3C;
		send(4'h6, 16'h0000);
		`CHK(test_current_on, 1'b1)
		`CHK(current_sink_channels, 16'hFFFF)
		read_back(4'h8);
		`CHK(test_current_on, 1'b0)
		`CHK(rd[15:0], 16'h5A3C)
		send(4'h2, 16'h0000);
		send(4'h0, 16'hFFFF);
		repeat (15) send(4'h0, 16'h0000);
		send(4'h2, 16'h0000);
		seen = 16'h0000;
		repeat (2000) begin
			@(posedge pclk);
			seen = seen | current_sink_channels;
		end
		`CHK(seen, 16'h8000)
		send(4'hA, 16'h2801);
		`CHK(config_word, 16'h2801)
		send(4'h0, 16'h0400);
		repeat (14) send(4'h0, 16'h0000);
		send(4'h2, 16'hFFF0);
		// Wait until the gray counter has passed channel 15's level
		while (current_sink_channels[15] !== 1'b0) begin
			@(posedge pclk);
		end
		`CHK(current_sink_channels, 16'h0001)
		send(4'hC, 16'h0000);
		`CHK(current_sink_channels[15], 1'b1)
		apb(1'b0, 8'h10, 32'h00000000);
		`CHK(err, 1'b1)
		conclude();
	end
endmodule : test_led_driver_serial_command
